/* include/fsd_pkg.sv */
// Shared constants, types and helpers for the float special-case datapath
package fsd_pkg;
  localparam int unsigned FSD_THREADS    = 8;
  localparam int unsigned FSD_TID_W      = 3;
  localparam int unsigned FSD_VF_LANES   = 4;
  localparam int unsigned FSD_MODE_BIT   = 0;
  localparam logic [31:0] FSD_CTL_RST    = 32'h0000_0000;
  localparam int unsigned FSD_VF_SIGN    = 7;
  localparam int unsigned FSD_VF_EXP_HI  = 6;
  localparam int unsigned FSD_VF_EXP_LO  = 4;
  localparam int unsigned FSD_VF_FRC_HI  = 3;
  // Excess-3 to excess-127: the 124 of the add, carried on into the top bits
  localparam logic [7:0]  FSD_VF_EXP_ADD = 8'h7C;
  localparam logic [18:0] FSD_VF_PAD     = 19'h0_0000;
  localparam logic [31:0] FSD_QNAN       = 32'h7FC0_0000;
  localparam logic [30:0] FSD_INF_MAG    = 31'h7F80_0000;
  localparam logic [30:0] FSD_FMAX_MAG   = 31'h7F7F_FFFF;
  localparam int          FSD_EXP_MAX    = 255;
  localparam int          FSD_MUL_BIAS   = 126;

  typedef enum logic [3:0] {
    FSD_OP_ADD, FSD_OP_SUB, FSD_OP_MUL, FSD_OP_RECIP, FSD_OP_RSQ,
    FSD_OP_SQRT, FSD_OP_LOG, FSD_OP_CMP, FSD_OP_CMPN, FSD_OP_VF
  } fsd_op_t;

  typedef enum logic [2:0] {
    FSD_CC_EQ, FSD_CC_NE, FSD_CC_GT, FSD_CC_GE, FSD_CC_LT, FSD_CC_LE
  } fsd_cond_t;

  function automatic logic fsdIsNan(input logic [31:0] x);
    return (&x[30:23]) && (|x[22:0]);
  endfunction

  function automatic logic fsdIsInf(input logic [31:0] x);
    return x[30:0] == FSD_INF_MAG;
  endfunction

  function automatic logic fsdIsZero(input logic [31:0] x);
    return x[30:0] == 31'h0000_0000;
  endfunction
endpackage

/* verilog/fsd_vf_unpack.sv */
// Widens a packed restricted-float immediate into single-precision lanes
`timescale 1ns/1ps
module fsd_vf_unpack import fsd_pkg::*; #(
  parameter int unsigned LANES = FSD_VF_LANES
) (
  input  wire logic [8*LANES-1:0]  vfImm,
  output logic      [32*LANES-1:0] vfVec
);
  genvar g;
  for (g = 0; g < LANES; g++) begin : gLane
    logic [7:0] el;
    logic [7:0] wideExp;
    assign el = vfImm[8*g +: 8];
    // Rebias from excess-3 to excess-127 in one add; field 000 lands on 0x7C
    assign wideExp = {5'h00, el[FSD_VF_EXP_HI:FSD_VF_EXP_LO]} + FSD_VF_EXP_ADD;
    // Only the all-zero magnitude is zero; exponent zero keeps the hidden one
    assign vfVec[32*g +: 32] = (el[FSD_VF_EXP_HI:0] == 7'h00) ?
      {el[FSD_VF_SIGN], 31'h0000_0000} :
      {el[FSD_VF_SIGN], wideExp, el[FSD_VF_FRC_HI:0], FSD_VF_PAD};
  end
endmodule

/* verilog/fsd_compare.sv */
// Ordinary and NaN-aware single-precision compare
`timescale 1ns/1ps
module fsd_compare import fsd_pkg::*; (
  input  wire logic [31:0] cmpA,
  input  wire logic [31:0] cmpB,
  input  wire fsd_cond_t   cmpCond,
  input  wire logic        nanAware,
  output logic             cmpTrue
);
  logic        aNan;
  logic        bNan;
  logic        isEq;
  logic        isLt;
  logic [31:0] keyA;
  logic [31:0] keyB;

  assign aNan = fsdIsNan(cmpA);
  assign bNan = fsdIsNan(cmpB);
  // Map sign-magnitude to an unsigned order; infinities stay exact
  assign keyA = cmpA[31] ? ~cmpA : (cmpA | 32'h8000_0000);
  assign keyB = cmpB[31] ? ~cmpB : (cmpB | 32'h8000_0000);
  assign isEq = (fsdIsZero(cmpA) && fsdIsZero(cmpB)) || (cmpA == cmpB);
  assign isLt = !isEq && (keyA < keyB);

  always_comb begin
    cmpTrue = 1'b0;
    if (nanAware && bNan) begin
      cmpTrue = (cmpCond != FSD_CC_NE);
    end else if (aNan || bNan) begin
      cmpTrue = (cmpCond == FSD_CC_NE);
    end else begin
      case (cmpCond)
        FSD_CC_EQ: cmpTrue = isEq;
        FSD_CC_NE: cmpTrue = !isEq;
        FSD_CC_GT: cmpTrue = !isEq && !isLt;
        FSD_CC_GE: cmpTrue = !isLt;
        FSD_CC_LT: cmpTrue = isLt;
        FSD_CC_LE: cmpTrue = isLt || isEq;
        default:   cmpTrue = 1'b0;
      endcase
    end
  end
endmodule

/* verilog/fsd_fp_special_case_datapath.sv */
// Float datapath: restricted-float unpack, per-thread mode, special cases
`timescale 1ns/1ps
module fsd_fp_special_case_datapath import fsd_pkg::*; #(
  parameter int unsigned THREADS = FSD_THREADS,
  parameter int unsigned TID_W   = FSD_TID_W
) (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   opValid,
  input  wire fsd_op_t                opCode,
  input  wire fsd_cond_t              cmpCond,
  input  wire logic [TID_W-1:0]       threadId,
  input  wire logic [31:0]            srcA,
  input  wire logic [31:0]            srcB,
  input  wire logic                   ctlWrEn,
  input  wire logic [TID_W-1:0]       ctlWrThread,
  input  wire logic [31:0]            ctlWrData,
  output logic                        resValid,
  output logic [31:0]                 resData,
  output logic [32*FSD_VF_LANES-1:0]  resVec,
  output logic                        resFlag,
  output logic                        resFinal,
  output logic [31:0]                 ctlRdData
);
  ////////////////////////////////////////////////////////////////////////
  // Rounding and arithmetic cores
  // Value of m[49] is 2^(e-127); m is nonzero; nearest-even with sticky
  function automatic logic [31:0] roundPack(input logic s, input int e,
                                            input logic [49:0] mIn);
    logic [49:0] m;
    logic [24:0] fr;
    logic        st;
    logic        up;
    int          ex;
    int          sh;
    m  = mIn;
    ex = e;
    for (int i = 0; i < 50; i++) begin
      if (!m[49]) begin
        m  = m << 1;
        ex = ex - 1;
      end
    end
    // Underflow walks into the denormal range with exponent field zero
    if (ex < 1) begin
      sh = 1 - ex;
      if (sh > 49) begin
        m = {49'h0, |m};
      end else begin
        st = |(m & ~({50{1'b1}} << sh));
        m  = (m >> sh) | {49'h0, st};
      end
      ex = 1;
    end
    up = m[25] && ((|m[24:0]) || m[26]);
    fr = {1'b0, m[49:26]} + {24'h0, up};
    if (fr[24]) begin
      fr = fr >> 1;
      ex = ex + 1;
    end
    if (!fr[23]) begin
      ex = 0;
    end
    if (ex >= FSD_EXP_MAX) begin
      return {s, FSD_INF_MAG};
    end
    return {s, ex[7:0], fr[22:0]};
  endfunction

  function automatic logic [31:0] mulCore(input logic [31:0] a, input logic [31:0] b);
    logic        s;
    logic [47:0] p;
    int          ea;
    int          eb;
    s  = a[31] ^ b[31];
    ea = (a[30:23] == 8'h00) ? 1 : int'(a[30:23]);
    eb = (b[30:23] == 8'h00) ? 1 : int'(b[30:23]);
    p  = {|a[30:23], a[22:0]} * {|b[30:23], b[22:0]};
    if (fsdIsNan(a) || fsdIsNan(b)) begin
      return FSD_QNAN;
    end
    if ((fsdIsInf(a) && fsdIsZero(b)) || (fsdIsZero(a) && fsdIsInf(b))) begin
      return FSD_QNAN;
    end
    if (fsdIsInf(a) || fsdIsInf(b)) begin
      return {s, FSD_INF_MAG};
    end
    if (fsdIsZero(a) || fsdIsZero(b)) begin
      return {s, 31'h0000_0000};
    end
    return roundPack(s, ea + eb - FSD_MUL_BIAS, {p, 2'b00});
  endfunction

  // Operand b arrives with its sign already flipped for subtraction
  function automatic logic [31:0] addCore(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] lg;
    logic [31:0] sm;
    logic [49:0] mL;
    logic [49:0] mS;
    logic [49:0] m;
    logic        st;
    int          eL;
    int          eS;
    int          d;
    lg = (a[30:0] >= b[30:0]) ? a : b;
    sm = (a[30:0] >= b[30:0]) ? b : a;
    eL = (lg[30:23] == 8'h00) ? 1 : int'(lg[30:23]);
    eS = (sm[30:23] == 8'h00) ? 1 : int'(sm[30:23]);
    d  = eL - eS;
    mL = {1'b0, |lg[30:23], lg[22:0], 25'h0};
    mS = {1'b0, |sm[30:23], sm[22:0], 25'h0};
    if (d > 49) begin
      mS = {49'h0, |mS};
    end else begin
      st = |(mS & ~({50{1'b1}} << d));
      mS = (mS >> d) | {49'h0, st};
    end
    m = (lg[31] == sm[31]) ? (mL + mS) : (mL - mS);
    if (fsdIsNan(a) || fsdIsNan(b)) begin
      return FSD_QNAN;
    end
    if (fsdIsInf(a) && fsdIsInf(b) && (a[31] != b[31])) begin
      return FSD_QNAN;
    end
    if (fsdIsInf(lg)) begin
      return lg;
    end
    if (fsdIsZero(a) && fsdIsZero(b)) begin
      return {a[31] & b[31], 31'h0000_0000};
    end
    if (m == 50'h0) begin
      return 32'h0000_0000;
    end
    return roundPack(lg[31], eL + 1, m);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Per-thread control registers written by the issue logic
  logic [31:0] ctlReg_r [THREADS];
  logic        legacyMode;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int t = 0; t < THREADS; t++) begin
        ctlReg_r[t] <= FSD_CTL_RST;
      end
    end else if (ctlWrEn) begin
      ctlReg_r[ctlWrThread] <= ctlWrData;
    end
  end

  // Mode is looked up per issued thread, so threads never share a setting
  assign legacyMode = ctlReg_r[threadId][FSD_MODE_BIT];
  assign ctlRdData  = ctlReg_r[ctlWrThread];

  ////////////////////////////////////////////////////////////////////////
  // Result selection
  logic [31:0]               uSrc;
  logic [31:0]               arithRes;
  logic [31:0]               selRes;
  logic                      selFinal;
  logic                      cmpTrue;
  logic [32*FSD_VF_LANES-1:0] vfVec;

  fsd_vf_unpack #(.LANES(FSD_VF_LANES)) uVf (
    .vfImm (srcA),
    .vfVec (vfVec)
  );

  fsd_compare uCmp (
    .cmpA     (srcA),
    .cmpB     (srcB),
    .cmpCond  (cmpCond),
    .nanAware (opCode == FSD_OP_CMPN),
    .cmpTrue  (cmpTrue)
  );

  // Legacy RSQ, SQRT and LOG take the magnitude first, so a negative operand gives no NaN; a NaN operand still does
  assign uSrc = legacyMode ? {1'b0, srcA[30:0]} : srcA;

  always_comb begin
    arithRes = 32'h0000_0000;
    selFinal = 1'b1;
    case (opCode)
      FSD_OP_ADD: arithRes = addCore(srcA, srcB);
      FSD_OP_SUB: arithRes = addCore(srcA, {~srcB[31], srcB[30:0]});
      FSD_OP_MUL: arithRes = mulCore(srcA, srcB);
      FSD_OP_RECIP: begin
        if (fsdIsNan(srcA)) arithRes = FSD_QNAN;
        else if (fsdIsInf(srcA)) arithRes = {srcA[31], 31'h0000_0000};
        else if (fsdIsZero(srcA)) arithRes = {srcA[31], FSD_INF_MAG};
        else selFinal = 1'b0;
      end
      FSD_OP_RSQ: begin
        if (fsdIsNan(uSrc)) arithRes = FSD_QNAN;
        else if (fsdIsZero(uSrc)) arithRes = {uSrc[31], FSD_INF_MAG};
        else if (uSrc[31]) arithRes = FSD_QNAN;
        else if (fsdIsInf(uSrc)) arithRes = 32'h0000_0000;
        else selFinal = 1'b0;
      end
      FSD_OP_SQRT: begin
        if (fsdIsNan(uSrc)) arithRes = FSD_QNAN;
        else if (fsdIsZero(uSrc)) arithRes = uSrc;
        else if (uSrc[31]) arithRes = FSD_QNAN;
        else if (fsdIsInf(uSrc)) arithRes = uSrc;
        else selFinal = 1'b0;
      end
      FSD_OP_LOG: begin
        if (fsdIsNan(uSrc)) arithRes = FSD_QNAN;
        else if (fsdIsZero(uSrc)) arithRes = {1'b1, FSD_INF_MAG};
        else if (uSrc[31]) arithRes = FSD_QNAN;
        else if (fsdIsInf(uSrc)) arithRes = uSrc;
        else selFinal = 1'b0;
      end
      FSD_OP_CMP, FSD_OP_CMPN: arithRes = {31'h0000_0000, cmpTrue};
      FSD_OP_VF: arithRes = vfVec[31:0];
      default: selFinal = 1'b0;
    endcase
  end

  // Legacy mode never emits an infinity: clamp to the signed largest finite
  assign selRes = (legacyMode && fsdIsInf(arithRes) && opCode != FSD_OP_CMP &&
                   opCode != FSD_OP_CMPN) ? {arithRes[31], FSD_FMAX_MAG} : arithRes;

  ////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resValid <= 1'b0;
    end else begin
      resValid <= opValid;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resData  <= 32'h0000_0000;
      resFinal <= 1'b0;
      resFlag  <= 1'b0;
    end else if (opValid) begin
      resData  <= selRes;
      resFinal <= selFinal;
      resFlag  <= (opCode == FSD_OP_CMP || opCode == FSD_OP_CMPN) && cmpTrue;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resVec <= '0;
    end else if (opValid && opCode == FSD_OP_VF) begin
      resVec <= vfVec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence sIeeeOp(fsd_op_t op, logic [31:0] val);
    opValid && opCode == op && !legacyMode && srcA == val;
  endsequence

  sequence sNanArith;
    opValid && (opCode == FSD_OP_ADD || opCode == FSD_OP_MUL) &&
      (fsdIsNan(srcA) || fsdIsNan(srcB)) && !legacyMode;
  endsequence

  a_recip_of_inf: assert property (@(posedge core_clk) disable iff (!nrst)
    sIeeeOp(FSD_OP_RECIP, 32'hFF80_0000) |=> resData == 32'h8000_0000 && resFinal)
    else $error("reciprocal of -inf is not -0");
  a_recip_of_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    sIeeeOp(FSD_OP_RECIP, 32'h0000_0000) |=> resData == 32'h7F80_0000)
    else $error("reciprocal of +0 is not +inf");
  a_sqrt_neg_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    sIeeeOp(FSD_OP_SQRT, 32'h8000_0000) |=> resData == 32'h8000_0000)
    else $error("sqrt of -0 is not -0");
  a_rsq_neg_nan: assert property (@(posedge core_clk) disable iff (!nrst)
    sIeeeOp(FSD_OP_RSQ, 32'hBF80_0000) |=> fsdIsNan(resData))
    else $error("rsq of negative finite is not NaN");
  a_log_zero_ninf: assert property (@(posedge core_clk) disable iff (!nrst)
    sIeeeOp(FSD_OP_LOG, 32'h8000_0000) |=> resData == 32'hFF80_0000)
    else $error("log of -0 is not -inf");
  a_nan_in_out: assert property (@(posedge core_clk) disable iff (!nrst)
    sNanArith |=> fsdIsNan(resData) && resValid)
    else $error("NaN operand did not give NaN");
  a_cmp_nan_flag: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && opCode == FSD_OP_CMP && fsdIsNan(srcB) |=> resFlag == (cmpCond == FSD_CC_NE))
    else $error("ordinary compare with NaN wrong");
  a_cmpn_src1_nan: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && opCode == FSD_OP_CMPN && fsdIsNan(srcB) |=> resFlag == (cmpCond != FSD_CC_NE))
    else $error("NaN-aware compare with NaN source two wrong");
  a_mul_one_exact: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && opCode == FSD_OP_MUL && srcB == 32'h3F80_0000 && !fsdIsNan(srcA) &&
      srcA[30:23] != 8'h00 && !legacyMode |=> resData == $past(srcA))
    else $error("x times one is not x");
  a_vf_widen: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && opCode == FSD_OP_VF && srcA[7:0] == 8'h01 |=> resVec[31:0] == 32'h3E08_0000)
    else $error("restricted float 0x01 widened wrongly");
  a_legacy_no_inf: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && legacyMode && opCode == FSD_OP_RECIP && fsdIsZero(srcA)
      |=> resData[30:0] == FSD_FMAX_MAG)
    else $error("legacy thread produced an infinity");
endmodule

/* verif/fsd_issue_model.sv */
// Issue-logic model that feeds operations and control writes to the datapath
`timescale 1ns/1ps
module fsd_issue_model import fsd_pkg::*; (
  input  wire logic                 core_clk,
  output logic                      opValid,
  output fsd_op_t                   opCode,
  output fsd_cond_t                 cmpCond,
  output logic [FSD_TID_W-1:0]      threadId,
  output logic [31:0]               srcA,
  output logic [31:0]               srcB,
  output logic                      ctlWrEn,
  output logic [FSD_TID_W-1:0]      ctlWrThread,
  output logic [31:0]               ctlWrData
);
  initial begin
    opValid     = 1'b0;
    opCode      = FSD_OP_ADD;
    cmpCond     = FSD_CC_EQ;
    threadId    = '0;
    srcA        = 32'h0000_0000;
    srcB        = 32'h0000_0000;
    ctlWrEn     = 1'b0;
    ctlWrThread = '0;
    ctlWrData   = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Leaves valid high on return so back-to-back calls form a continuous burst
  task automatic issue(input fsd_op_t op, input fsd_cond_t cc,
                       input logic [FSD_TID_W-1:0] tid, input logic [31:0] a,
                       input logic [31:0] b);
    @(negedge core_clk);
    opValid  = 1'b1;
    opCode   = op;
    cmpCond  = cc;
    threadId = tid;
    srcA     = a;
    srcB     = b;
    @(posedge core_clk);
  endtask

  // Released operands show inverted junk, never the last value
  task automatic idle();
    @(negedge core_clk);
    opValid  = 1'b0;
    srcA     = ~srcA;
    srcB     = ~srcB;
    threadId = ~threadId;
  endtask

  task automatic write_ctl(input logic [FSD_TID_W-1:0] tid, input logic [31:0] d);
    @(negedge core_clk);
    ctlWrEn     = 1'b1;
    ctlWrThread = tid;
    ctlWrData   = d;
    @(posedge core_clk);
    @(negedge core_clk);
    ctlWrEn   = 1'b0;
    ctlWrData = ~d;
  endtask
endmodule

/* verif/fsd_fp_special_case_datapath_bench.sv */
// Self-checking bench for the float special-case datapath
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module fsd_fp_special_case_datapath_bench import fsd_pkg::*;;
  logic                     core_clk;
  logic                     nrst;
  logic                     opValid, ctlWrEn, resValid, resFlag, resFinal;
  fsd_op_t                  opCode;
  fsd_cond_t                cmpCond;
  logic [FSD_TID_W-1:0]     threadId, ctlWrThread;
  logic [31:0]              srcA, srcB, ctlWrData, resData, ctlRdData;
  logic [32*FSD_VF_LANES-1:0] resVec;
  int                       fails, cmp_count, cycles;

  fsd_issue_model i_issue (.core_clk(core_clk), .opValid(opValid), .opCode(opCode),
    .cmpCond(cmpCond), .threadId(threadId), .srcA(srcA), .srcB(srcB), .ctlWrEn(ctlWrEn),
    .ctlWrThread(ctlWrThread), .ctlWrData(ctlWrData));

  fsd_fp_special_case_datapath i_dut (.core_clk(core_clk), .nrst(nrst), .opValid(opValid),
    .opCode(opCode), .cmpCond(cmpCond), .threadId(threadId), .srcA(srcA), .srcB(srcB),
    .ctlWrEn(ctlWrEn), .ctlWrThread(ctlWrThread), .ctlWrData(ctlWrData),
    .resValid(resValid), .resData(resData), .resVec(resVec), .resFlag(resFlag),
    .resFinal(resFinal), .ctlRdData(ctlRdData));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_op(input fsd_op_t op, input logic [FSD_TID_W-1:0] tid,
                        input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
    i_issue.issue(op, FSD_CC_EQ, tid, a, b);
    i_issue.idle();
    `CHK(resValid, 1'b1)
    `CHK(resFinal, 1'b1)
    `CHK(resFlag, 1'b0)
    `CHK(resData, exp)
  endtask

  // Widened lane worked out bit by bit from the element layout
  function automatic logic [31:0] vf_lane(input logic [7:0] b);
    if (b[6:0] == 7'h00) begin
      return {b[7], 31'h0000_0000};
    end
    return {b[7], b[6], {5{~b[6]}}, b[5:4], b[3:0], 19'h0_0000};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_vf();
    logic [31:0] imm [3];
    imm = '{32'h8000_7F01, 32'hF09A_3C0F, 32'h0081_5020};
    foreach (imm[k]) begin
      i_issue.issue(FSD_OP_VF, FSD_CC_EQ, '0, imm[k], 32'h0000_0000);
      i_issue.idle();
      `CHK(resData, vf_lane(imm[k][7:0]))
      for (int i = 0; i < 4; i++) begin
        `CHK(resVec[32*i+:32], vf_lane(imm[k][8*i+:8]))
      end
    end
  endtask

  task automatic t_special();
    chk_op(FSD_OP_RECIP, 0, 32'h7F80_0000, 32'h0, 32'h0000_0000);
    chk_op(FSD_OP_RECIP, 0, 32'hFF80_0000, 32'h0, 32'h8000_0000);
    chk_op(FSD_OP_MUL, 0, 32'h7F80_0000, 32'h0000_0000, FSD_QNAN);
    chk_op(FSD_OP_SUB, 0, 32'h7F80_0000, 32'h7F80_0000, FSD_QNAN);
    chk_op(FSD_OP_ADD, 0, 32'h7F80_0000, 32'hFF80_0000, FSD_QNAN);
    chk_op(FSD_OP_RECIP, 0, 32'h0000_0000, 32'h0, 32'h7F80_0000);
    chk_op(FSD_OP_RECIP, 0, 32'h8000_0000, 32'h0, 32'hFF80_0000);
    chk_op(FSD_OP_RSQ, 0, 32'h0000_0000, 32'h0, 32'h7F80_0000);
    chk_op(FSD_OP_RSQ, 0, 32'h8000_0000, 32'h0, 32'hFF80_0000);
    chk_op(FSD_OP_SQRT, 0, 32'h8000_0000, 32'h0, 32'h8000_0000);
    chk_op(FSD_OP_RSQ, 0, 32'hBF80_0000, 32'h0, FSD_QNAN);
    chk_op(FSD_OP_SQRT, 0, 32'h8000_0001, 32'h0, FSD_QNAN);
    chk_op(FSD_OP_LOG, 0, 32'h0000_0000, 32'h0, 32'hFF80_0000);
    chk_op(FSD_OP_LOG, 0, 32'h8000_0000, 32'h0, 32'hFF80_0000);
    chk_op(FSD_OP_LOG, 0, 32'hBF80_0000, 32'h0, FSD_QNAN);
    chk_op(FSD_OP_LOG, 0, 32'hFF80_0000, 32'h0, FSD_QNAN);
    chk_op(FSD_OP_ADD, 0, 32'h7FC0_0001, 32'h3F80_0000, FSD_QNAN);
    chk_op(FSD_OP_MUL, 0, 32'h3F80_0000, 32'h7FA0_0000, FSD_QNAN);
    // Ties on the half ulp expose truncation and round-half-up alike
    chk_op(FSD_OP_ADD, 0, 32'h3F80_0000, 32'h3380_0000, 32'h3F80_0000);
    chk_op(FSD_OP_ADD, 0, 32'h3F80_0001, 32'h3380_0000, 32'h3F80_0002);
    chk_op(FSD_OP_MUL, 0, 32'h3F80_0001, 32'h3F80_0001, 32'h3F80_0002);
    chk_op(FSD_OP_MUL, 0, 32'hC0A0_0000, 32'h3F80_0000, 32'hC0A0_0000);
    chk_op(FSD_OP_SUB, 0, 32'h4000_0000, 32'h3F80_0000, 32'h3F80_0000);
  endtask

  // Mask bit n is the expected outcome for condition code n
  task automatic cmp_case(input fsd_op_t op, input logic [31:0] a, input logic [31:0] b,
                          input logic [5:0] mask);
    for (int i = 0; i < 6; i++) begin
      i_issue.issue(op, fsd_cond_t'(i), '0, a, b);
      i_issue.idle();
      `CHK(resFlag, mask[i])
      `CHK(resData[0], mask[i])
    end
  endtask

  task automatic t_cmp();
    cmp_case(FSD_OP_CMP, FSD_QNAN, 32'h3F80_0000, 6'h02);
    cmp_case(FSD_OP_CMP, 32'h3F80_0000, FSD_QNAN, 6'h02);
    cmp_case(FSD_OP_CMPN, 32'h3F80_0000, FSD_QNAN, 6'h3D);
    cmp_case(FSD_OP_CMPN, FSD_QNAN, FSD_QNAN, 6'h3D);
    cmp_case(FSD_OP_CMPN, FSD_QNAN, 32'h3F80_0000, 6'h02);
    cmp_case(FSD_OP_CMP, 32'h3F80_0000, 32'h7F80_0000, 6'h32);
    cmp_case(FSD_OP_CMPN, 32'h7F80_0000, 32'h7F80_0000, 6'h29);
    cmp_case(FSD_OP_CMP, 32'hFF80_0000, 32'hFF80_0000, 6'h29);
  endtask

  task automatic t_mode();
    i_issue.write_ctl(3'h1, 32'h0000_0001);
    `CHK(ctlRdData, 32'h0000_0001)
    i_issue.write_ctl(3'h2, 32'hFFFF_FFFE);
    `CHK(ctlRdData, 32'hFFFF_FFFE)
    // Back-to-back ops from threads in different modes
    i_issue.issue(FSD_OP_RECIP, FSD_CC_EQ, 3'h1, 32'h0000_0000, 32'h0);
    #1;
    `CHK(resData, 32'h7F7F_FFFF)
    i_issue.issue(FSD_OP_RECIP, FSD_CC_EQ, 3'h0, 32'h0000_0000, 32'h0);
    i_issue.idle();
    `CHK(resData, 32'h7F80_0000)
    chk_op(FSD_OP_MUL, 3'h1, 32'h7F7F_FFFF, 32'h4000_0000, 32'h7F7F_FFFF);
    chk_op(FSD_OP_MUL, 3'h0, 32'h7F7F_FFFF, 32'h4000_0000, 32'h7F80_0000);
    chk_op(FSD_OP_RECIP, 3'h2, 32'h0000_0000, 32'h0, 32'h7F80_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fails     = 0;
    cmp_count = 0;
    cycles    = 0;
    nrst      = 1'b0;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    `CHK(resValid, 1'b0)
    `CHK(ctlRdData, 32'h0000_0000)
    t_vf();
    t_special();
    t_cmp();
    t_mode();
    summarize();
  end
endmodule
